// >>> common/ocp_defs.svh
// Register offsets, field positions, reset values and codes of the oscillator control block.
// Assumes inclusion by bare name from the package; the design file uses the macros without including it.
`ifndef OCP_DEFS_SVH
`define OCP_DEFS_SVH

// ==========================================
// Register offsets
`define OCP_ADDR_W        4
`define OCP_OFF_HXTCTL    4'h0
`define OCP_OFF_LXTCTL    4'h1
`define OCP_OFF_SYSCLK    4'h2
`define OCP_OFF_RCCTL     4'h3
`define OCP_OFF_STATUS    4'h4

// ==========================================
// Field positions
`define OCP_BIT_EN        0
`define OCP_BIT_STABLE    1
`define OCP_BIT_MODE      2
`define OCP_BIT_SUB_HALT  0
`define OCP_BIT_HI_HALT   1
`define OCP_BIT_LSRC      2
`define OCP_SEL_LSB       5
`define OCP_SEL_MSB       7
`define OCP_BIT_PDF       0
`define OCP_BIT_TO        1
`define OCP_BIT_SLOW      2
`define OCP_MODE_LSB      4
`define OCP_MODE_MSB      6

// ==========================================
// Reset values and codes
`define OCP_RST_BYTE      8'h00
`define OCP_SEL_SUB       3'h7
`define OCP_SEL_DIV1      3'h0
`define OCP_DRV_CNT_W     3

`endif

// >>> common/ocp_pkg.sv
// Types shared by the oscillator control and operating-mode block.
// Assumes ocp_defs.svh sits beside it on the include path.
package ocp_pkg;
	`include "ocp_defs.svh"

	// ==========================================
	// Operating modes
	typedef enum logic [2:0] {
		OCP_FAST,
		OCP_SLOW,
		OCP_SLEEP,
		OCP_IDLE_SUB_ONLY,
		OCP_IDLE_BOTH_CLOCKS,
		OCP_IDLE_HIGH_ONLY
	} ocp_mode_t;

	// ==========================================
	// Oscillator enables driven to the analog cells
	typedef struct packed {
		logic hxt_on;
		logic hxt_drive;
		logic lxt_on;
		logic lxt_speed_up;
		logic low_speed_rc_osc_on;
		logic rc_on;
	} ocp_osc_t;

	// ==========================================
	// Clock gating and selection toward the clock tree
	typedef struct packed {
		logic [2:0] sys_sel;
		logic       sub_is_lxt;
		logic       fh_run;
		logic       fsub_run;
		logic       f4k_run;
		logic       sys_run;
	} ocp_clk_t;
endpackage

// >>> design/ocp_ctrl.sv
// Oscillator enables, system clock switching and halt mode decoding.
// Assumes oscillator ready levels and core events synchronous to mclk.
`timescale 1ns/100ps

// What this block does
// [R1] Software sets drive select for crystal speed before enabling the crystal.
// [R2] Drive select writes ignored while crystal pins assigned and crystal enabled.
// [R3] Drive select writable whenever either crystal pin is not assigned.
// [R4] Enabling high crystal clears its stable flag, set again once stable.
// [R5] Bits 7 to 3 of both crystal registers read zero.
// [R6] High crystal register bit 0 enables the high-speed crystal.
// [R7] Low crystal bit 2 selects speed-up or low-power operation.
// [R8] Speed-up bit frozen once low crystal is the system clock source.
// [R9] Enabling low crystal clears its stable flag, set again once stable.
// [R10] Low crystal register bit 0 enables the low-speed crystal.
// [R11] Clock select 111 moves to SLOW mode on the sub clock.
// [R12] Sub clock from low crystal or RC by source bit, switch waits stable.
// [R13] Codes 000 to 110 give FAST mode, high clock divided 1 to 64.
// [R14] Software polls stable flag before relying on FAST after high clock stopped.
// [R15] Halt picks SLEEP or IDLE from the two halt clock bits.
// [R16] Both halt bits zero: SLEEP, system clock stopped, execution held.
// [R17] In SLEEP only the 4 kHz clock runs, if watchdog or time base on.
// [R18] In SLEEP and IDLE the selected low oscillator stays on.
// [R19] Halt entry leaves memory, registers and ports unchanged.
// [R20] Halt entry sets power-down flag and clears watchdog time-out flag.
// [R21] Halt entry clears watchdog counter; it counts on only if enabled.
// [R22] High bit 0, sub bit 1: IDLE_SUB_ONLY, high clock off, sub clock on.
// [R23] Both bits one: IDLE_BOTH_CLOCKS, both clocks run, execution stopped.
// [R24] High bit 1, sub bit 0: IDLE_HIGH_ONLY, high clock on, sub clock off.
// [R25] RC stable flag cleared on RC enable, set once stable.
// [R26] System clock mux changes only after target stable flag is set.
// [R27] Stable flags ignore writes; crystal register bits reset to zero.
module ocp_ctrl
	import ocp_pkg::*;
#(
	parameter int ADDR_W = `OCP_ADDR_W
) (
	input  wire logic              mclk,
	input  wire logic              resetn,
	input  wire logic              clk_en,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [7:0]        wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic [7:0]             rdata_r,
	input  wire logic              crystal_pin_in_assigned,
	input  wire logic              crystal_pin_out_assigned,
	input  wire logic              hxt_ready,
	input  wire logic              lxt_ready,
	input  wire logic              low_speed_rc_osc_ready,
	input  wire logic              rc_ready,
	input  wire logic              halt_exec,
	input  wire logic              wake,
	input  wire logic              wdt_clear_instr,
	input  wire logic              wdt_timeout,
	input  wire logic              wdt_enable,
	input  wire logic              time_base_enable,
	output ocp_osc_t               osc_r,
	output ocp_clk_t               clk_r,
	output ocp_mode_t              mode_r,
	output logic                   cpu_hold_r,
	output logic                   wdt_clear_r,
	output logic                   wdt_run_r,
	output logic                   power_down_flag_r,
	output logic                   watchdog_timeout_flag_r
);

	// ==========================================
	// Elaboration check
	if (ADDR_W < `OCP_ADDR_W) begin : g_chk
		$error("ocp_ctrl: ADDR_W too small for the register map");
	end

	// ==========================================
	// Register state
	logic       hxt_en_r, hxt_drv_r, hxt_stable_r;
	logic       lxt_en_r, lxt_sp_r, lxt_stable_r;
	logic       rc_en_r, rc_stable_r;
	logic [2:0] sel_req_r;
	logic       lsrc_r, hi_halt_r, sub_halt_r;
	logic       low_speed_rc_osc_stable_r;
	ocp_mode_t  mode_nxt;

	function automatic logic wr_hit(input logic [ADDR_W-1:0] a, input logic [3:0] off);
		return wr && (a == ADDR_W'(off));
	endfunction

	function automatic logic halted(input ocp_mode_t m);
		return (m != OCP_FAST) && (m != OCP_SLOW);
	endfunction

	// ==========================================
	// High-speed crystal control
	logic hxt_pins_osc;
	assign hxt_pins_osc = crystal_pin_in_assigned && crystal_pin_out_assigned;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			hxt_en_r  <= 1'b0; // [R27]
			hxt_drv_r <= 1'b0; // [R27]
		end else if (clk_en && wr_hit(addr, `OCP_OFF_HXTCTL)) begin
			hxt_en_r <= wdata[`OCP_BIT_EN]; // [R6]
			// Locked only while the crystal is enabled with both of its pins assigned
			if (!(hxt_pins_osc && hxt_en_r)) begin // [R2]
				hxt_drv_r <= wdata[`OCP_BIT_MODE]; // [R3]
			end
		end
	end

	// Rising enable restarts the stability wait; ready must be seen again after that
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			hxt_stable_r <= 1'b0;
		end else if (clk_en) begin
			if (!hxt_en_r || (wr_hit(addr, `OCP_OFF_HXTCTL) && wdata[`OCP_BIT_EN] && !hxt_en_r)) begin
				hxt_stable_r <= 1'b0; // [R4]
			end else if (hxt_ready) begin
				hxt_stable_r <= 1'b1; // [R4]
			end
		end
	end

	// ==========================================
	// Low-speed crystal control
	logic lxt_is_sys;
	assign lxt_is_sys = (clk_r.sys_sel == `OCP_SEL_SUB) && clk_r.sub_is_lxt;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			lxt_en_r <= 1'b0; // [R27]
			lxt_sp_r <= 1'b0; // [R27]
		end else if (clk_en && wr_hit(addr, `OCP_OFF_LXTCTL)) begin
			lxt_en_r <= wdata[`OCP_BIT_EN]; // [R10]
			if (!lxt_is_sys) begin // [R8]
				lxt_sp_r <= wdata[`OCP_BIT_MODE]; // [R7]
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			lxt_stable_r <= 1'b0;
		end else if (clk_en) begin
			if (!lxt_en_r || (wr_hit(addr, `OCP_OFF_LXTCTL) && wdata[`OCP_BIT_EN] && !lxt_en_r)) begin
				lxt_stable_r <= 1'b0; // [R9]
			end else if (lxt_ready) begin
				lxt_stable_r <= 1'b1; // [R9]
			end
		end
	end

	// ==========================================
	// RC oscillator control
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rc_en_r <= 1'b0;
		end else if (clk_en && wr_hit(addr, `OCP_OFF_RCCTL)) begin
			rc_en_r <= wdata[`OCP_BIT_EN];
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rc_stable_r <= 1'b0;
		end else if (clk_en) begin
			if (!rc_en_r || (wr_hit(addr, `OCP_OFF_RCCTL) && wdata[`OCP_BIT_EN] && !rc_en_r)) begin
				rc_stable_r <= 1'b0; // [R25]
			end else if (rc_ready) begin
				rc_stable_r <= 1'b1; // [R25]
			end
		end
	end

	// Low RC is on unless the low crystal is the sub source outside halt; its flag only follows the cell's ready level
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			low_speed_rc_osc_stable_r <= 1'b0;
		end else if (clk_en) begin
			low_speed_rc_osc_stable_r <= low_speed_rc_osc_ready;
		end
	end

	// ==========================================
	// System clock control
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sel_req_r  <= `OCP_SEL_DIV1;
			lsrc_r     <= 1'b0;
			hi_halt_r  <= 1'b0;
			sub_halt_r <= 1'b0;
		end else if (clk_en && wr_hit(addr, `OCP_OFF_SYSCLK)) begin
			sel_req_r  <= wdata[`OCP_SEL_MSB:`OCP_SEL_LSB];
			lsrc_r     <= wdata[`OCP_BIT_LSRC];
			hi_halt_r  <= wdata[`OCP_BIT_HI_HALT];
			sub_halt_r <= wdata[`OCP_BIT_SUB_HALT];
		end
	end

	// Target readiness for the requested source
	logic sub_ok, high_ok, tgt_ok;
	assign sub_ok  = lsrc_r ? lxt_stable_r : low_speed_rc_osc_stable_r; // [R12]
	assign high_ok = hxt_stable_r || rc_stable_r;
	assign tgt_ok  = (sel_req_r == `OCP_SEL_SUB) ? sub_ok : high_ok;

	// Mux moves only onto a stable source; a divide change on fH waits for either high stable flag
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			clk_r.sys_sel    <= `OCP_SEL_DIV1;
			clk_r.sub_is_lxt <= 1'b0;
		end else if (clk_en && tgt_ok) begin // [R26]
			clk_r.sys_sel    <= sel_req_r; // [R11] [R13]
			clk_r.sub_is_lxt <= lsrc_r; // [R12]
		end
	end

	// ==========================================
	// Operating mode
	always_comb begin
		mode_nxt = mode_r;
		if (halted(mode_r)) begin
			if (wake) begin
				mode_nxt = (clk_r.sys_sel == `OCP_SEL_SUB) ? OCP_SLOW : OCP_FAST;
			end
		end else if (halt_exec) begin
			unique case ({hi_halt_r, sub_halt_r}) // [R15]
				2'b00: mode_nxt = OCP_SLEEP; // [R16]
				2'b01: mode_nxt = OCP_IDLE_SUB_ONLY; // [R22]
				2'b11: mode_nxt = OCP_IDLE_BOTH_CLOCKS; // [R23]
				2'b10: mode_nxt = OCP_IDLE_HIGH_ONLY; // [R24]
			endcase
		end else begin
			mode_nxt = (clk_r.sys_sel == `OCP_SEL_SUB) ? OCP_SLOW : OCP_FAST; // [R11] [R13]
		end
	end

	// Only mode state changes here; registers and ports keep their values
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mode_r     <= OCP_FAST;
			cpu_hold_r <= 1'b0;
		end else if (clk_en) begin
			mode_r     <= mode_nxt; // [R19]
			cpu_hold_r <= halted(mode_nxt); // [R16]
		end
	end

	// ==========================================
	// Clock gating per mode
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			clk_r.fh_run   <= 1'b1;
			clk_r.fsub_run <= 1'b1;
			clk_r.f4k_run  <= 1'b0;
			clk_r.sys_run  <= 1'b1;
		end else if (clk_en) begin
			clk_r.f4k_run <= wdt_enable || time_base_enable; // [R17]
			unique case (mode_nxt)
				OCP_SLEEP: begin
					clk_r.fh_run   <= 1'b0; // [R17]
					clk_r.fsub_run <= 1'b0; // [R17]
					clk_r.sys_run  <= 1'b0; // [R16]
				end
				OCP_IDLE_SUB_ONLY: begin
					clk_r.fh_run   <= 1'b0; // [R22]
					clk_r.fsub_run <= 1'b1; // [R22]
					clk_r.sys_run  <= 1'b0;
				end
				OCP_IDLE_BOTH_CLOCKS: begin
					clk_r.fh_run   <= 1'b1; // [R23]
					clk_r.fsub_run <= 1'b1; // [R23]
					clk_r.sys_run  <= 1'b0;
				end
				OCP_IDLE_HIGH_ONLY: begin
					clk_r.fh_run   <= 1'b1; // [R24]
					clk_r.fsub_run <= 1'b0; // [R24]
					clk_r.sys_run  <= 1'b0;
				end
				OCP_FAST, OCP_SLOW: begin
					clk_r.fh_run   <= 1'b1;
					clk_r.fsub_run <= 1'b1;
					clk_r.sys_run  <= 1'b1;
				end
			endcase
		end
	end

	// ==========================================
	// Oscillator enables toward the analog cells
	logic halt_now;
	assign halt_now = halted(mode_nxt);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			osc_r <= '0;
		end else if (clk_en) begin
			osc_r.hxt_on       <= hxt_en_r; // [R6]
			osc_r.hxt_drive    <= hxt_drv_r;
			osc_r.lxt_speed_up <= lxt_sp_r; // [R7]
			osc_r.rc_on        <= rc_en_r;
			// Selected low source is held on through any halt for the 4 kHz clock
			osc_r.lxt_on  <= lxt_en_r || (halt_now && lsrc_r); // [R10] [R18]
			osc_r.low_speed_rc_osc_on <= !lsrc_r || halt_now; // [R18]
		end
	end

	// ==========================================
	// Watchdog and status flags on halt
	logic halt_entry;
	assign halt_entry = !halted(mode_r) && halt_exec;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wdt_clear_r <= 1'b0;
			wdt_run_r   <= 1'b0;
		end else if (clk_en) begin
			wdt_clear_r <= halt_entry || wdt_clear_instr; // [R21]
			wdt_run_r   <= wdt_enable; // [R21]
		end
	end

	// A time-out in the halt cycle still wins over its clear
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			power_down_flag_r       <= 1'b0;
			watchdog_timeout_flag_r <= 1'b0;
		end else if (clk_en) begin
			if (halt_entry) begin
				power_down_flag_r <= 1'b1; // [R20]
			end else if (wdt_clear_instr) begin
				power_down_flag_r <= 1'b0;
			end
			if (wdt_timeout) begin
				watchdog_timeout_flag_r <= 1'b1;
			end else if (halt_entry || wdt_clear_instr) begin
				watchdog_timeout_flag_r <= 1'b0; // [R20]
			end
		end
	end

	// ==========================================
	// Read port, data one cycle after the strobe
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = `OCP_RST_BYTE; // [R5]
		unique case (addr[`OCP_ADDR_W-1:0])
			`OCP_OFF_HXTCTL: begin
				rd_mux[`OCP_BIT_EN]     = hxt_en_r;
				rd_mux[`OCP_BIT_STABLE] = hxt_stable_r; // [R27]
				rd_mux[`OCP_BIT_MODE]   = hxt_drv_r;
			end
			`OCP_OFF_LXTCTL: begin
				rd_mux[`OCP_BIT_EN]     = lxt_en_r;
				rd_mux[`OCP_BIT_STABLE] = lxt_stable_r; // [R27]
				rd_mux[`OCP_BIT_MODE]   = lxt_sp_r;
			end
			`OCP_OFF_SYSCLK: begin
				rd_mux[`OCP_SEL_MSB:`OCP_SEL_LSB] = sel_req_r;
				rd_mux[`OCP_BIT_LSRC]     = lsrc_r;
				rd_mux[`OCP_BIT_HI_HALT]  = hi_halt_r;
				rd_mux[`OCP_BIT_SUB_HALT] = sub_halt_r;
			end
			`OCP_OFF_RCCTL: begin
				rd_mux[`OCP_BIT_EN]     = rc_en_r;
				rd_mux[`OCP_BIT_STABLE] = rc_stable_r; // [R14]
			end
			`OCP_OFF_STATUS: begin
				rd_mux[`OCP_BIT_PDF]  = power_down_flag_r;
				rd_mux[`OCP_BIT_TO]   = watchdog_timeout_flag_r;
				rd_mux[`OCP_BIT_SLOW] = (clk_r.sys_sel == `OCP_SEL_SUB);
				rd_mux[`OCP_MODE_MSB:`OCP_MODE_LSB] = mode_r;
			end
			default: rd_mux = `OCP_RST_BYTE;
		endcase
		// Shift rather than slice so the default width needs no empty part-select
		if ((addr >> `OCP_ADDR_W) != '0) begin
			rd_mux = `OCP_RST_BYTE;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rdata_r <= `OCP_RST_BYTE;
		end else if (clk_en) begin
			rdata_r <= rd ? rd_mux : `OCP_RST_BYTE;
		end
	end

endmodule

// >>> tb/ocp_ctrl_sva.sv
// Port assertions for the oscillator control block.
// Assumes the single clock mclk and asynchronous active-low resetn.
`timescale 1ns/100ps
module ocp_ctrl_sva
	import ocp_pkg::*;
(
	input wire logic      mclk,
	input wire logic      resetn,
	input wire logic      lxt_ready,
	input wire logic      halt_exec,
	input wire logic      wdt_timeout,
	input wire logic      wdt_enable,
	input wire logic      time_base_enable,
	input wire ocp_osc_t  osc_r,
	input wire ocp_clk_t  clk_r,
	input wire ocp_mode_t mode_r,
	input wire logic      cpu_hold_r,
	input wire logic      wdt_clear_r,
	input wire logic      power_down_flag_r,
	input wire logic      watchdog_timeout_flag_r
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	// ==========================================
	// Halt entry
	sequence s_halt;
		halt_exec && !cpu_hold_r;
	endsequence
	sequence s_flags;
		##[1:2] (power_down_flag_r && !watchdog_timeout_flag_r);
	endsequence

	a_halt_stops: assert property (s_halt |=> cpu_hold_r && !clk_r.sys_run)
		else $error("halt did not stop execution");
	a_halt_flags: assert property (s_halt ##0 !wdt_timeout |-> s_flags)
		else $error("halt flags wrong");
	a_wdt_cleared: assert property (s_halt |-> ##[1:2] wdt_clear_r)
		else $error("watchdog not cleared on halt");

	// ==========================================
	// Clock gating in each halt mode
	a_sleep_clocks: assert property (mode_r == OCP_SLEEP |->
		!clk_r.fh_run && !clk_r.fsub_run) else $error("clock runs in sleep");
	a_idle_sub: assert property (mode_r == OCP_IDLE_SUB_ONLY |->
		!clk_r.fh_run && clk_r.fsub_run) else $error("idle sub gating wrong");
	a_idle_both: assert property (mode_r == OCP_IDLE_BOTH_CLOCKS |->
		clk_r.fh_run && clk_r.fsub_run) else $error("idle both gating wrong");
	a_idle_high: assert property (mode_r == OCP_IDLE_HIGH_ONLY |->
		clk_r.fh_run && !clk_r.fsub_run) else $error("idle high gating wrong");
	// Forcing is registered on the same edge as cpu_hold_r, yet the check waits one held cycle
	a_f4k_halt: assert property (cpu_hold_r && $past(cpu_hold_r) |->
		clk_r.f4k_run == $past(wdt_enable || time_base_enable) &&
		(osc_r.low_speed_rc_osc_on || osc_r.lxt_on)) else $error("slow source off in halt");

	// ==========================================
	// Switching, register locks and reset values
	a_lxt_switch: assert property ($changed(clk_r.sys_sel) && clk_r.sys_sel == 3'h7 &&
		clk_r.sub_is_lxt |-> $past(lxt_ready, 2)) else $error("switched before stable");
	a_speed_frozen: assert property ($past(clk_r.sys_sel, 2) == 3'h7 &&
		$past(clk_r.sub_is_lxt, 2) |-> $stable(osc_r.lxt_speed_up))
		else $error("speed-up changed while running");
	a_reset_zero: assert property ($rose(resetn) |->
		!(osc_r.hxt_on || osc_r.hxt_drive || osc_r.lxt_on || osc_r.lxt_speed_up))
		else $error("crystal bits not zero after reset");
endmodule

bind ocp_ctrl ocp_ctrl_sva u_sva (
	.mclk(mclk), .resetn(resetn), .lxt_ready(lxt_ready), .halt_exec(halt_exec),
	.wdt_timeout(wdt_timeout), .wdt_enable(wdt_enable),
	.time_base_enable(time_base_enable), .osc_r(osc_r), .clk_r(clk_r), .mode_r(mode_r),
	.cpu_hold_r(cpu_hold_r), .wdt_clear_r(wdt_clear_r),
	.power_down_flag_r(power_down_flag_r), .watchdog_timeout_flag_r(watchdog_timeout_flag_r)
);

// >>> tb/test_ocp_ctrl.sv
// Self-checking bench for the oscillator control block.
// Assumes ocp_pkg and the bound checker compile first.
`timescale 1ns/100ps
module test_ocp_ctrl;
	import ocp_pkg::*;
	logic       mclk = 1'b0;
	logic       resetn = 1'b0;
	logic       wr = 1'b0, rd = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, rdata_r, v;
	logic       pin_in = 1'b1, pin_out = 1'b1, hxt_ready = 1'b0, lxt_ready = 1'b0;
	logic       halt_exec = 1'b0, wake = 1'b0, wdt_clr = 1'b0, wdt_to = 1'b0;
	logic       wdt_en = 1'b0, tb_en = 1'b0, clk_en = 1'b1, rc_rdy = 1'b0;
	logic       cpu_hold_r, wdt_clear_r, wdt_run_r, power_down_flag, to_flag;
	ocp_osc_t   osc_r;
	ocp_clk_t   clk_r;
	ocp_mode_t  mode_r;
	ocp_mode_t  exp_m [4] = '{OCP_SLEEP, OCP_IDLE_SUB_ONLY, OCP_IDLE_HIGH_ONLY,
		OCP_IDLE_BOTH_CLOCKS};
	int         n_errors = 0, total_checks = 0;

	ocp_ctrl dut (
		.mclk(mclk), .resetn(resetn), .clk_en(clk_en), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata_r(rdata_r), .crystal_pin_in_assigned(pin_in),
		.crystal_pin_out_assigned(pin_out), .hxt_ready(hxt_ready), .lxt_ready(lxt_ready),
		.low_speed_rc_osc_ready(1'b1), .rc_ready(rc_rdy), .halt_exec(halt_exec), .wake(wake),
		.wdt_clear_instr(wdt_clr), .wdt_timeout(wdt_to), .wdt_enable(wdt_en),
		.time_base_enable(tb_en), .osc_r(osc_r), .clk_r(clk_r), .mode_r(mode_r),
		.cpu_hold_r(cpu_hold_r), .wdt_clear_r(wdt_clear_r), .wdt_run_r(wdt_run_r),
		.power_down_flag_r(power_down_flag), .watchdog_timeout_flag_r(to_flag)
	);

	initial begin
		forever #50 mclk = ~mclk;
	end

	// ==========================================
	// Bus and check helpers
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 d = rdata_r;
	endtask

	// ==========================================
	// Scenarios
	task automatic t_reset;
		rd_reg(4'h0, v);
		chk(v, 8'h00);
		rd_reg(4'h1, v);
		chk(v, 8'h00);
		rd_reg(4'h5, v);
		chk(v, 8'h00);
		// A write while the clock enable is low must leave no trace
		@(posedge mclk) clk_en <= 1'b0;
		wr_reg(4'h0, 8'h05);
		clk_en <= 1'b1;
		rd_reg(4'h0, v);
		chk(v, 8'h00);
		chk({7'h00, osc_r.hxt_on}, 8'h00);
		$display("end reset values");
	endtask
	task automatic t_high;
		wr_reg(4'h0, 8'h04);
		wr_reg(4'h0, 8'hfd);
		rd_reg(4'h0, v);
		chk(v, 8'h05);
		chk({7'h00, osc_r.hxt_on}, 8'h01);
		@(posedge mclk) hxt_ready <= 1'b1;
		rd_reg(4'h0, v);
		chk(v, 8'h07);
		wr_reg(4'h0, 8'h01);
		rd_reg(4'h0, v);
		chk(v, 8'h07);
		@(posedge mclk) pin_out <= 1'b0;
		wr_reg(4'h0, 8'h01);
		rd_reg(4'h0, v);
		chk(v, 8'h03);
		chk({7'h00, osc_r.hxt_drive}, 8'h00);
		wr_reg(4'h3, 8'h01);
		rd_reg(4'h3, v);
		chk(v, 8'h01);
		chk({7'h00, osc_r.rc_on}, 8'h01);
		@(posedge mclk) rc_rdy <= 1'b1;
		rd_reg(4'h3, v);
		chk(v, 8'h03);
		$display("end high crystal");
	endtask
	task automatic t_low;
		wr_reg(4'h1, 8'h05);
		rd_reg(4'h1, v);
		chk(v, 8'h05);
		wr_reg(4'h2, 8'he4);
		cyc(3);
		chk({5'h00, clk_r.sys_sel}, 8'h00);
		@(posedge mclk) lxt_ready <= 1'b1;
		cyc(4);
		chk({4'h0, clk_r.sub_is_lxt, clk_r.sys_sel}, 8'h0f);
		chk({5'h00, mode_r}, {5'h00, OCP_SLOW});
		rd_reg(4'h4, v);
		chk(v, 8'h14);
		wr_reg(4'h1, 8'h01);
		rd_reg(4'h1, v);
		chk(v, 8'h07);
		chk({6'h00, osc_r.lxt_on, osc_r.lxt_speed_up}, 8'h03);
		$display("end low crystal");
	endtask
	task automatic t_fast;
		rd_reg(4'h0, v);
		chk(v, 8'h03);
		for (int i = 0; i < 7; i++) begin
			wr_reg(4'h2, {i[2:0], 5'h04});
			cyc(3);
			chk({5'h00, clk_r.sys_sel}, {5'h00, i[2:0]});
			chk({5'h00, mode_r}, {5'h00, OCP_FAST});
		end
		$display("end fast codes");
	endtask
	task automatic t_halt;
		logic seen;
		for (int i = 0; i < 4; i++) begin
			wr_reg(4'h2, {6'h00, i[1:0]});
			@(posedge mclk);
			wdt_clr <= 1'b1;
			wdt_en <= i[1];
			tb_en <= i == 1;
			@(posedge mclk);
			wdt_clr <= 1'b0;
			wdt_to <= 1'b1;
			@(posedge mclk);
			wdt_to <= 1'b0;
			halt_exec <= 1'b1;
			#1;
			chk({6'h00, power_down_flag, to_flag}, 8'h01);
			@(posedge mclk);
			halt_exec <= 1'b0;
			#1 seen = wdt_clear_r;
			chk({5'h00, mode_r}, {5'h00, exp_m[i]});
			chk({4'h0, cpu_hold_r, clk_r.sys_run, clk_r.fh_run, clk_r.fsub_run},
				{6'h02, i[1:0]});
			chk({7'h00, clk_r.f4k_run}, {7'h00, i != 0});
			cyc(1);
			seen |= wdt_clear_r;
			chk({7'h00, seen}, 8'h01);
			chk({6'h00, power_down_flag, to_flag}, 8'h02);
			chk({6'h00, wdt_run_r, osc_r.low_speed_rc_osc_on}, {6'h00, i[1], 1'b1});
			@(posedge mclk);
			wake <= 1'b1;
			@(posedge mclk);
			wake <= 1'b0;
			#1;
			chk({6'h00, cpu_hold_r, mode_r == OCP_FAST}, 8'h01);
			rd_reg(4'h0, v);
			chk(v, 8'h03);
			rd_reg(4'h4, v);
			chk(v, 8'h01);
		end
		$display("end halt modes");
	endtask

	// ==========================================
	// Run control
	task automatic finish_test;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		t_reset();
		t_high();
		t_low();
		t_fast();
		t_halt();
		finish_test();
	end

	// The tests need well under 300 cycles; this allows ample margin
	initial begin
		#200_000;
		n_errors++;
		finish_test();
	end
endmodule
